// ===== pib_pkg.sv
// What this block does
// - Flags latch on events regardless of enables
// - Requests reach CPU only with peripheral-global enable
// - Second enable register bit layout, bits 2-1 absent
// - Third enable register bit layout, sparse bits
// - Fourth enable register holds only bits 1-0
// - First request register flag order bit 7-0
// - USART receive/transmit flags read-only to software
// - Second request register mirrors second enable layout
// - Third request register mirrors third enable layout
// - Flag reads one while its request pends
// - Unimplemented bits always read as zero
// - All implemented bits clear on any reset
// - Enable gates request, never touches the flag
// - Serial-port-2 flags set by hardware, software clears
package pib_pkg;

    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam logic [11:0] ADDR_CTRL     = 12'h000;
    localparam logic [11:0] ADDR_EN_BASE  = 12'h004;
    localparam logic [11:0] ADDR_REQ_BASE = 12'h014;
    localparam logic [11:0] ADDR_STATUS   = 12'h024;
    localparam logic [11:0] ADDR_MASK     = 12'h028;
    localparam int          NUM_BANKS     = 4;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int CTRL_GLOBAL_BIT = 7;
    localparam int CTRL_PERIPH_BIT = 6;
    localparam int REQ_A_RX_BIT    = 5;
    localparam int REQ_A_TX_BIT    = 4;
    localparam int STAT_REQ_BIT    = 0;
    localparam int STAT_LOST_BIT   = 1;

    // ****************************************
    // Implemented and writable masks, bank a..d
    // ****************************************
    localparam logic [3:0][7:0] IMPL_MASK = {8'h03, 8'h3A, 8'hF9, 8'hFF};
    localparam logic [3:0][7:0] REQ_WMASK = {8'h03, 8'h3A, 8'hF9, 8'hCF};
    localparam logic [7:0]      CTRL_MASK = 8'hC0;
    localparam logic [7:0]      STAT_MASK = 8'h03;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0]  RESET_BYTE = 8'h00;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    // Register group selected by an address
    typedef enum {
        SEL_CTRL,
        SEL_EN,
        SEL_REQ,
        SEL_STATUS,
        SEL_MASK,
        SEL_NONE
    } pib_sel_type;

endpackage

// ===== pib_irq_bank.sv
`timescale 1ns/100ps
module pib_irq_bank import pib_pkg::*; (
    // APB slave
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    input  wire logic [3:0]           pstrb,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // Peripheral event pulses, bank a..d
    input  wire logic [3:0][7:0]      periph_event,
    // USART hardware clears for read-only flags
    input  wire logic                 usart_receive_clear,
    input  wire logic                 usart_transmit_clear,
    // Requests toward the CPU
    output logic                      periph_irq_req,
    output logic                      cpu_irq_req,
    // Block interrupt
    output logic                      irq
);

    // ****************************************
    // Address decode
    // ****************************************

    // Used for both read and write paths
    function automatic pib_sel_type decode_sel(input logic [11:0] addr);
        if (addr == ADDR_CTRL) begin
            return SEL_CTRL;
        end else if (addr >= ADDR_EN_BASE && addr < ADDR_REQ_BASE && addr[1:0] == 2'b00) begin
            return SEL_EN;
        end else if (addr >= ADDR_REQ_BASE && addr < ADDR_STATUS && addr[1:0] == 2'b00) begin
            return SEL_REQ;
        end else if (addr == ADDR_STATUS) begin
            return SEL_STATUS;
        end else if (addr == ADDR_MASK) begin
            return SEL_MASK;
        end else begin
            return SEL_NONE;
        end
    endfunction

    // Bank index within an enable or request group
    function automatic logic [1:0] decode_bank(input logic [11:0] addr, input logic [11:0] base);
        logic [11:0] diff;
        diff = addr - base;
        return diff[3:2];
    endfunction

    pib_sel_type     sel;
    logic [1:0]      bank;
    logic            setup_phase;
    logic            wr_fire;
    logic            rd_fire;

    assign sel         = decode_sel(paddr);
    assign bank        = (sel == SEL_EN) ? decode_bank(paddr, ADDR_EN_BASE)
                                         : decode_bank(paddr, ADDR_REQ_BASE);
    assign setup_phase = psel & ~penable;
    // Zero wait states; data is prepared in the setup cycle
    assign pready      = 1'b1;
    assign wr_fire     = psel & penable & pwrite & pstrb[0] & (sel != SEL_NONE);
    assign rd_fire     = psel & penable & ~pwrite;

    // ****************************************
    // Control, enable and flag storage
    // ****************************************
    logic [7:0]           ctrl_r;
    logic [3:0][7:0]      en_r;
    logic [3:0][7:0]      req_r;
    logic [3:0][7:0]      req_nxt;
    logic [7:0]           status_r;
    logic [7:0]           status_nxt;
    logic [7:0]           mask_r;
    logic [7:0]           lost_evt;
    logic                 gated_req;
    logic                 gated_req_d_r;

    // Global enables; unimplemented bits never stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= RESET_BYTE;
        end else if (wr_fire && sel == SEL_CTRL) begin
            ctrl_r <= pwdata[7:0] & CTRL_MASK;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_BANKS; g++) begin : g_bank
            logic [7:0] hw_clr;
            logic       wr_en;
            logic       wr_req;

            assign wr_en  = wr_fire && sel == SEL_EN && bank == 2'(g);
            assign wr_req = wr_fire && sel == SEL_REQ && bank == 2'(g);

            // USART flags are cleared only by the USART itself
            if (g == 0) begin : g_usart
                assign hw_clr = {2'b00, usart_receive_clear, usart_transmit_clear, 4'h0};
            end else begin : g_plain
                assign hw_clr = 8'h00;
            end

            // Enable bits only gate; they never alter a flag
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    en_r[g] <= RESET_BYTE;
                end else if (wr_en) begin
                    en_r[g] <= pwdata[7:0] & IMPL_MASK[g];
                end
            end

            // Hardware clear first, then software write; events win over any clear
            always_comb begin
                req_nxt[g] = req_r[g] & ~hw_clr;
                if (wr_req) begin
                    req_nxt[g] = (req_nxt[g] & ~REQ_WMASK[g])
                               | (pwdata[7:0] & REQ_WMASK[g]);
                end
                req_nxt[g] = (req_nxt[g] | periph_event[g]) & IMPL_MASK[g];
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    req_r[g] <= RESET_BYTE;
                end else begin
                    req_r[g] <= req_nxt[g];
                end
            end

            // Event landing on an already pending flag
            assign lost_evt[g] = |(periph_event[g] & req_r[g] & IMPL_MASK[g]);
        end
    endgenerate

    assign lost_evt[7:NUM_BANKS] = '0;

    // ****************************************
    // Request forwarding
    // ****************************************

    // Enabled and pending in any bank, then the peripheral-global gate
    always_comb begin
        gated_req = 1'b0;
        for (int i = 0; i < NUM_BANKS; i++) begin
            gated_req = gated_req | (|(en_r[i] & req_r[i]));
        end
        gated_req = gated_req & ctrl_r[CTRL_PERIPH_BIT];
    end

    assign periph_irq_req = gated_req;
    assign cpu_irq_req    = gated_req & ctrl_r[CTRL_GLOBAL_BIT];

    // ****************************************
    // Block status and interrupt
    // ****************************************

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gated_req_d_r <= 1'b0;
        end else begin
            gated_req_d_r <= gated_req;
        end
    end

    // Read clears only what it returned; a same-cycle event still sets
    always_comb begin
        status_nxt = status_r;
        if (rd_fire && sel == SEL_STATUS) begin
            // Data was taken in setup, so an event since then must survive
            status_nxt = status_r & ~prdata[7:0];
        end
        status_nxt[STAT_REQ_BIT]  = status_nxt[STAT_REQ_BIT] | (gated_req & ~gated_req_d_r);
        status_nxt[STAT_LOST_BIT] = status_nxt[STAT_LOST_BIT] | (|lost_evt);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_r <= RESET_BYTE;
        end else begin
            status_r <= status_nxt & STAT_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_r <= RESET_BYTE;
        end else if (wr_fire && sel == SEL_MASK) begin
            mask_r <= pwdata[7:0] & STAT_MASK;
        end
    end

    assign irq = |(status_r & mask_r);

    // ****************************************
    // Read data and error response
    // ****************************************

    // Captured in setup so the access phase needs no wait
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= RESET_WORD;
            pslverr <= 1'b0;
        end else if (setup_phase) begin
            pslverr <= (sel == SEL_NONE);
            prdata  <= RESET_WORD;
            if (!pwrite) begin
                unique case (sel)
                    SEL_CTRL:   prdata[7:0] <= ctrl_r;
                    SEL_EN:     prdata[7:0] <= en_r[bank];
                    SEL_REQ:    prdata[7:0] <= req_r[bank];
                    SEL_STATUS: prdata[7:0] <= status_r;
                    SEL_MASK:   prdata[7:0] <= mask_r;
                    SEL_NONE:   prdata[7:0] <= RESET_BYTE;
                endcase
            end
        end
    end

endmodule

// ===== pib_irq_bank_chk.sv
`timescale 1ns/100ps
module pib_irq_bank_chk import pib_pkg::*; (
    // APB side
    input wire logic            pclk,
    input wire logic            presetn,
    input wire logic            psel,
    input wire logic            penable,
    input wire logic            pwrite,
    input wire logic [11:0]     paddr,
    input wire logic [31:0]     pwdata,
    input wire logic [3:0]      pstrb,
    input wire logic [31:0]     prdata,
    input wire logic            pslverr,
    // Events and requests
    input wire logic [3:0][7:0] periph_event,
    input wire logic            periph_irq_req,
    input wire logic            cpu_irq_req
);
    // ****
    // Helpers
    // ****
    logic [11:0] off;
    logic        rds;
    assign off = paddr - ADDR_EN_BASE;
    assign rds = psel && !penable && !pwrite;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Any reset leaves no request standing
    reset_clear_a: assert property ($rose(presetn) |-> !periph_irq_req)
        else $error("request high after reset");
    gate_off_a: assert property (
        psel && penable && pwrite && pstrb[0] && paddr == ADDR_CTRL && !pwdata[CTRL_PERIPH_BIT]
        |=> !periph_irq_req) else $error("peripheral gate ignored");
    cpu_gate_a: assert property (cpu_irq_req |-> periph_irq_req)
        else $error("cpu request without peripheral request");
    upper_zero_a: assert property (rds |=> prdata[31:8] == 24'h00_0000)
        else $error("upper read bits set");
    // Bank index only valid for aligned addresses
    unimpl_zero_a: assert property (
        rds && paddr >= ADDR_EN_BASE && paddr < ADDR_STATUS
        |=> (prdata[7:0] & ~IMPL_MASK[$past(off[3:2])]) == 8'h00)
        else $error("unimplemented bit read as one");
    // Event two edges before setup; a write just before may clear it,
    // and the USART flags have their own clear, so both are left out
    event_latch_a: assert property (
        rds && paddr == ADDR_REQ_BASE && !$past(psel && penable && pwrite)
        |=> (prdata[7:0] & $past(periph_event[0], 3) & REQ_WMASK[0])
            == ($past(periph_event[0], 3) & REQ_WMASK[0]))
        else $error("event not latched");
    unmapped_err_a: assert property (
        rds && paddr > ADDR_MASK |=> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped read not refused");
    mapped_ok_a: assert property (
        rds && paddr <= ADDR_MASK && paddr[1:0] == 2'b00 |=> !pslverr)
        else $error("mapped read refused");
endmodule

// ===== pib_periph_model.sv
`timescale 1ns/100ps
module pib_periph_model (
    // Clock
    input  wire logic       pclk,
    // Event lines toward the bank
    output logic [3:0][7:0] periph_event,
    output logic            usart_receive_clear,
    output logic            usart_transmit_clear
);
    // Quiet until a peripheral fires
    initial begin
        periph_event = '0;
        usart_receive_clear = 1'b0;
        usart_transmit_clear = 1'b0;
    end
    // One-cycle event, whatever the enables hold
    task automatic pulse(input int k, input logic [7:0] b);
        @(posedge pclk);
        periph_event[k] <= b;
        @(posedge pclk);
        periph_event[k] <= 8'h00;
    endtask
    // USART drains, dropping both its flags
    task automatic uclr;
        @(posedge pclk);
        usart_receive_clear <= 1'b1;
        usart_transmit_clear <= 1'b1;
        @(posedge pclk);
        usart_receive_clear <= 1'b0;
        usart_transmit_clear <= 1'b0;
    endtask
endmodule

// ===== pib_irq_bank_test.sv
`timescale 1ns/100ps
module pib_irq_bank_test import pib_pkg::*; ();
    localparam logic [31:0] Z = 32'h0000_0000;
    logic            pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0]     paddr, ea, ra;
    logic [31:0]     pwdata, prdata, q;
    logic [3:0]      pstrb;
    logic [3:0][7:0] periph_event;
    logic            usart_receive_clear, usart_transmit_clear;
    logic            periph_irq_req, cpu_irq_req, irq;
    logic [7:0]      r;
    logic [7:0]      impl [4] = '{8'hFF, 8'hF9, 8'h3A, 8'h03};
    int              mismatches, n_checks;
    pib_irq_bank pib_irq_bank_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .periph_event(periph_event), .usart_receive_clear(usart_receive_clear),
        .usart_transmit_clear(usart_transmit_clear), .periph_irq_req(periph_irq_req),
        .cpu_irq_req(cpu_irq_req), .irq(irq));
    pib_periph_model pib_periph_model_inst (.pclk(pclk), .periph_event(periph_event),
        .usart_receive_clear(usart_receive_clear),
        .usart_transmit_clear(usart_transmit_clear));
    // ****
    // Tasks
    // ****
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, s, e);
        end
    endtask
    // Holds the request until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) mismatches++;
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, Z);
        check(q, e);
    endtask
    // Requests are combinational, so look mid-cycle
    task automatic outs(input logic [1:0] e);
        @(negedge pclk);
        check(32'({periph_irq_req, cpu_irq_req}), 32'(e));
    endtask
    // USART flags never take software writes
    function automatic logic [31:0] wexp(int k, logic [7:0] v, logic f);
        return 32'(v & ((f && k == 0) ? 8'hCF : impl[k]));
    endfunction
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // Hang guard, far beyond the sequence length
    initial begin
        repeat (5000) @(posedge pclk);
        mismatches++;
        conclude();
    end
    initial begin
        {mismatches, n_checks, psel, penable, pwrite, paddr, pwdata} = '0;
        pstrb = 4'h1;
        presetn = 1'b0;
        void'($urandom(55));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a <= 'h28; a += 4) rd(a[11:0], Z);
        rd(12'h02C, Z);
        check(32'(pslverr), 32'h0000_0001);
        for (int k = 0; k < 4; k++) begin
            ea = ADDR_EN_BASE + 12'(4 * k);
            ra = ADDR_REQ_BASE + 12'(4 * k);
            r = 8'($urandom);
            apb(1'b1, ea, 32'(r));
            rd(ea, wexp(k, r, 1'b0));
            apb(1'b1, ra, 32'(r));
            rd(ra, wexp(k, r, 1'b1));
            apb(1'b1, ea, Z);
            apb(1'b1, ra, Z);
            r = 8'($urandom);
            pib_periph_model_inst.pulse(k, r);
            rd(ra, 32'(r & impl[k]));
            outs(2'b00);
            apb(1'b1, ra, Z);
            rd(ra, k == 0 ? 32'(r & 8'h30) : Z);
            pib_periph_model_inst.uclr;
            rd(ra, Z);
        end
        // Serial-port-2 collision through both gates
        apb(1'b1, ADDR_MASK, 32'h0000_0001);
        // A write without its low strobe leaves the mask alone
        pstrb <= 4'h0;
        apb(1'b1, ADDR_MASK, 32'h0000_0003);
        pstrb <= 4'h1;
        rd(ADDR_MASK, 32'h0000_0001);
        apb(1'b1, ADDR_EN_BASE + 12'h00C, 32'h0000_0002);
        pib_periph_model_inst.pulse(3, 8'h02);
        outs(2'b00);
        apb(1'b1, ADDR_CTRL, 32'h0000_0040);
        outs(2'b10);
        apb(1'b1, ADDR_CTRL, 32'h0000_00C0);
        outs(2'b11);
        check(32'(irq), 32'h0000_0001);
        rd(ADDR_STATUS, 32'h0000_0001);
        outs(2'b11);
        check(32'(irq), Z);
        // Dropping the peripheral gate drops both requests
        apb(1'b1, ADDR_CTRL, 32'h0000_0080);
        outs(2'b00);
        apb(1'b1, ADDR_CTRL, 32'h0000_00C0);
        rd(ADDR_STATUS, 32'h0000_0001);
        apb(1'b1, ADDR_EN_BASE + 12'h00C, Z);
        outs(2'b00);
        rd(ADDR_REQ_BASE + 12'h00C, 32'h0000_0002);
        // Event on a pending flag: flag stays, status notes it
        pib_periph_model_inst.pulse(3, 8'h02);
        rd(ADDR_REQ_BASE + 12'h00C, 32'h0000_0002);
        rd(ADDR_STATUS, 32'h0000_0002);
        rd(ADDR_STATUS, Z);
        // Second reset with a request standing
        apb(1'b1, ADDR_EN_BASE + 12'h00C, 32'h0000_0002);
        outs(2'b11);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        outs(2'b00);
        check(32'(irq), Z);
        rd(ADDR_REQ_BASE + 12'h00C, Z);
        rd(ADDR_MASK, Z);
        rd(ADDR_CTRL, Z);
        conclude();
    end
endmodule
bind pib_irq_bank pib_irq_bank_chk pib_irq_bank_chk_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pslverr(pslverr), .periph_event(periph_event),
    .periph_irq_req(periph_irq_req), .cpu_irq_req(cpu_irq_req));
